// *** hdl/ovl_pkg.sv ***
package ovl_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned TICK_PERIOD_NS = 1000000;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_SUBMODE = 8'h00;
    localparam logic [7:0] ADDR_MAX_CUR = 8'h04;
    localparam logic [7:0] ADDR_RATED = 8'h08;
    localparam logic [7:0] ADDR_PEAK_SET = 8'h0c;
    localparam logic [7:0] ADDR_PEAK_DUR = 8'h10;
    localparam logic [7:0] ADDR_THRESH = 8'h14;
    localparam logic [7:0] ADDR_LOAD = 8'h18;
    localparam logic [7:0] ADDR_LIMIT = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int unsigned SUBMODE_CLOSED_LOOP_BIT = 0;
    localparam logic [31:0] RST_SUBMODE = 32'h0000_0000;
    localparam logic [15:0] RST_SETTING = 16'h0000;
    localparam logic [47:0] RST_WIDE = 48'h0000_0000_0000;
    localparam logic [47:0] LOAD_MAX = 48'hffff_ffff_ffff;
    localparam logic [31:0] STATUS_OFF = 32'h0000_0000;
    localparam logic [31:0] STATUS_ON = 32'h0000_0001;

    // Tenths of a percent, and mA^2 to A^2
    localparam logic [31:0] PEAK_SCALE = 32'h0000_03e8;
    localparam logic [47:0] A2MS_SCALE = 48'h0000_000f_4240;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_PEAK = 3'b010,
        ST_RATED = 3'b100
    } ovl_state_t;

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [31:0] ovl_sq16(input logic [15:0] x);
        return {16'h0000, x} * {16'h0000, x};
    endfunction

    function automatic logic [31:0] ovl_to_a2ms(input logic [47:0] x);
        logic [47:0] q;
        q = x / A2MS_SCALE;
        return q[31:0];
    endfunction

    function automatic logic [15:0] ovl_wr16(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) r[7:0] = d[7:0];
        if (strb[1]) r[15:8] = d[15:8];
        return r;
    endfunction

endpackage

// *** hdl/ovl_acc_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface ovl_acc_if;
    logic en;
    logic tick;
    logic [31:0] meas_sq;
    logic [31:0] rated_sq;
    logic [47:0] load;

    modport ctl(output en, output tick, output meas_sq, output rated_sq, input load);
    modport acc(input en, input tick, input meas_sq, input rated_sq, output load);
endinterface
`default_nettype wire

// *** hdl/ovl_ms_tick.sv ***
`timescale 1ns/10ps
`default_nettype none
module ovl_ms_tick
#(
    parameter int unsigned CYCLES = 200000
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Time base
    output logic tick
);
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt_ff;
    logic tick_ff;
    logic nxt_tick_ff;

    always_comb begin
        nxt_cnt_ff = cnt_ff + 32'h0000_0001;
        nxt_tick_ff = 1'b0;
        if (cnt_ff >= 32'(CYCLES - 1)) begin
            nxt_cnt_ff = 32'h0000_0000;
            nxt_tick_ff = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt_ff;
            tick_ff <= nxt_tick_ff;
        end
    end

    assign tick = tick_ff;
endmodule
`default_nettype wire

// *** hdl/ovl_load_acc.sv ***
`timescale 1ns/10ps
`default_nettype none
module ovl_load_acc
    import ovl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Controller side
    ovl_acc_if.acc acc
);
    logic [47:0] load_ff;
    logic [47:0] nxt_load_ff;
    logic [48:0] sum;
    logic [47:0] dec;

    always_comb begin
        sum = {1'b0, load_ff} + {17'h0_0000, acc.meas_sq - acc.rated_sq};
        dec = {16'h0000, acc.rated_sq - acc.meas_sq};
        nxt_load_ff = load_ff;
        if (!acc.en) begin
            nxt_load_ff = RST_WIDE;
        end else if (acc.tick) begin
            // Square law: larger overcurrent fills faster
            if (acc.meas_sq >= acc.rated_sq) begin
                nxt_load_ff = sum[48] ? LOAD_MAX : sum[47:0];
            end else if (load_ff > dec) begin
                nxt_load_ff = load_ff - dec;
            end else begin
                // Recovery floors at zero, never wraps
                nxt_load_ff = RST_WIDE;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            load_ff <= RST_WIDE;
        end else begin
            load_ff <= nxt_load_ff;
        end
    end

    assign acc.load = load_ff;
endmodule
`default_nettype wire

// *** hdl/ovl_limiter_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// Function
// - The limiter works only while bit 0 of the drive submode register is one.
// - The absolute motor current is a mA setting that the applied peak never exceeds.
// - The rated current is a mA setting used as the level once the budget is spent.
// - The peak setting counts tenths of a percent of the rated current.
// - The allowed peak duration is a setting in milliseconds.
// - A readable budget limit in A^2ms decides between peak and rated limit.
// - A readable accumulated load in A^2ms is compared with the budget while active.
// - The limit presently imposed is readable in mA.
// - A readable status is zero while inactive and one while active.
// - Without all four settings valid, peak above rated and nonzero duration, it stays off.
// - The budget is derived from rated current, peak current and duration while active.
// - Peak current is allowed until the load reaches the budget, then rated at once.
// - The peak current used is clamped to the absolute motor current.
// - Larger overcurrent fills the load faster, so the peak reaches the budget sooner.
module ovl_limiter_top
    import ovl_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Current controller
    input wire logic [15:0] measured_current_ma,
    output logic [15:0] current_limit_ma,
    output logic limiter_active
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [31:0] submode_ff;
    logic [31:0] nxt_submode_ff;
    logic [15:0] max_cur_ff;
    logic [15:0] nxt_max_cur_ff;
    logic [15:0] rated_ff;
    logic [15:0] nxt_rated_ff;
    logic [15:0] peak_set_ff;
    logic [15:0] nxt_peak_set_ff;
    logic [15:0] dur_ff;
    logic [15:0] nxt_dur_ff;
    logic [47:0] budget_ff;
    logic [47:0] nxt_budget_ff;
    logic [15:0] limit_ff;
    logic [15:0] nxt_limit_ff;
    ovl_state_t state_ff;
    ovl_state_t nxt_state_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata_ff;
    logic pslverr_ff;
    logic nxt_pslverr_ff;

    logic wr_en;
    logic setup;
    logic [31:0] peak_raw;
    logic [31:0] peak_prod;
    logic [15:0] peak_ma;
    logic [31:0] peak_sq;
    logic [31:0] rated_sq;
    logic [47:0] budget;
    logic closed_loop;
    logic valid;
    logic ms_tick;

    ovl_acc_if acc_bus();

    // ****************************************
    // APB register writes
    // ****************************************
    assign setup = psel & ~penable;
    // Zero wait states, so every access phase completes
    assign wr_en = psel & penable & pwrite;

    always_comb begin
        nxt_submode_ff = submode_ff;
        nxt_max_cur_ff = max_cur_ff;
        nxt_rated_ff = rated_ff;
        nxt_peak_set_ff = peak_set_ff;
        nxt_dur_ff = dur_ff;
        if (wr_en) begin
            case (paddr)
                ADDR_SUBMODE: begin
                    for (int i = 0; i < 4; i++) begin
                        if (pstrb[i]) nxt_submode_ff[i*8 +: 8] = pwdata[i*8 +: 8];
                    end
                end
                ADDR_MAX_CUR: nxt_max_cur_ff = ovl_wr16(max_cur_ff, pwdata, pstrb);
                ADDR_RATED: nxt_rated_ff = ovl_wr16(rated_ff, pwdata, pstrb);
                ADDR_PEAK_SET: nxt_peak_set_ff = ovl_wr16(peak_set_ff, pwdata, pstrb);
                ADDR_PEAK_DUR: nxt_dur_ff = ovl_wr16(dur_ff, pwdata, pstrb);
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            submode_ff <= RST_SUBMODE;
            max_cur_ff <= RST_SETTING;
            rated_ff <= RST_SETTING;
            peak_set_ff <= RST_SETTING;
            dur_ff <= RST_SETTING;
        end else begin
            submode_ff <= nxt_submode_ff;
            max_cur_ff <= nxt_max_cur_ff;
            rated_ff <= nxt_rated_ff;
            peak_set_ff <= nxt_peak_set_ff;
            dur_ff <= nxt_dur_ff;
        end
    end

    // ****************************************
    // APB read path
    // ****************************************
    // Read data captured in setup, so it is stable through the access phase
    always_comb begin
        nxt_prdata_ff = prdata_ff;
        nxt_pslverr_ff = pslverr_ff;
        if (setup) begin
            nxt_pslverr_ff = 1'b0;
            nxt_prdata_ff = 32'h0000_0000;
            case (paddr)
                ADDR_SUBMODE: nxt_prdata_ff = submode_ff;
                ADDR_MAX_CUR: nxt_prdata_ff = {16'h0000, max_cur_ff};
                ADDR_RATED: nxt_prdata_ff = {16'h0000, rated_ff};
                ADDR_PEAK_SET: nxt_prdata_ff = {16'h0000, peak_set_ff};
                ADDR_PEAK_DUR: nxt_prdata_ff = {16'h0000, dur_ff};
                ADDR_THRESH: nxt_prdata_ff = ovl_to_a2ms(budget_ff);
                ADDR_LOAD: nxt_prdata_ff = ovl_to_a2ms(acc_bus.load);
                ADDR_LIMIT: nxt_prdata_ff = {16'h0000, limit_ff};
                ADDR_STATUS: nxt_prdata_ff = (state_ff == ST_OFF) ? STATUS_OFF : STATUS_ON;
                default: nxt_pslverr_ff = 1'b1;
            endcase
            if (pwrite) begin
                nxt_prdata_ff = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata_ff;
            pslverr_ff <= nxt_pslverr_ff;
        end
    end

    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = pslverr_ff & psel & penable;

    // ****************************************
    // Peak current and budget
    // ****************************************
    assign peak_prod = {16'h0000, rated_ff} * {16'h0000, peak_set_ff};
    assign peak_raw = peak_prod / PEAK_SCALE;
    // Clamp keeps the peak within the absolute motor current
    assign peak_ma = (peak_raw > {16'h0000, max_cur_ff}) ? max_cur_ff : peak_raw[15:0];
    assign peak_sq = ovl_sq16(peak_ma);
    assign rated_sq = ovl_sq16(rated_ff);
    assign budget = {16'h0000, peak_sq - rated_sq} * {32'h0000_0000, dur_ff};

    assign closed_loop = submode_ff[SUBMODE_CLOSED_LOOP_BIT];
    // Clamped peak must still exceed rated, else there is no headroom
    assign valid = closed_loop & (max_cur_ff != RST_SETTING) & (rated_ff != RST_SETTING)
                   & (dur_ff != RST_SETTING) & (peak_ma > rated_ff);

    always_comb begin
        nxt_budget_ff = RST_WIDE;
        if (valid) begin
            nxt_budget_ff = budget;
        end
    end

    // ****************************************
    // Millisecond time base and load
    // ****************************************
    ovl_ms_tick #(
        .CYCLES(TICK_LEN)
    ) u_tick (
        .clock(clock),
        .rst_b(rst_b),
        .tick(ms_tick)
    );

    assign acc_bus.en = valid;
    assign acc_bus.tick = ms_tick;
    assign acc_bus.meas_sq = ovl_sq16(measured_current_ma);
    assign acc_bus.rated_sq = rated_sq;

    ovl_load_acc u_acc (
        .clock(clock),
        .rst_b(rst_b),
        .acc(acc_bus.acc)
    );

    // ****************************************
    // Limit selection
    // ****************************************
    always_comb begin
        nxt_state_ff = ST_OFF;
        if (!valid) begin
            nxt_state_ff = ST_OFF;
        end else if (acc_bus.load >= budget_ff) begin
            nxt_state_ff = ST_RATED;
        end else begin
            nxt_state_ff = ST_PEAK;
        end
    end

    always_comb begin
        case (nxt_state_ff)
            ST_PEAK: nxt_limit_ff = peak_ma;
            ST_RATED: nxt_limit_ff = rated_ff;
            ST_OFF: nxt_limit_ff = max_cur_ff;
            default: nxt_limit_ff = max_cur_ff;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_OFF;
            limit_ff <= RST_SETTING;
            budget_ff <= RST_WIDE;
        end else begin
            state_ff <= nxt_state_ff;
            limit_ff <= nxt_limit_ff;
            budget_ff <= nxt_budget_ff;
        end
    end

    assign current_limit_ma = limit_ff;
    assign limiter_active = (state_ff != ST_OFF);

endmodule
`default_nettype wire

// *** test/ovl_limiter_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module ovl_limiter_monitor
    import ovl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Controller
    input wire logic [15:0] measured_current_ma,
    input wire logic [15:0] current_limit_ma,
    input wire logic limiter_active
);
    // **********
    // Settings shadow
    // **********
    // Quiet masks the cycles in which settings and budget still settle
    logic wr;
    logic quiet;
    logic sub_ff, nxt_sub;
    logic [15:0] max_ff, nxt_max, rated_ff, nxt_rated;
    logic [2:0] hist_ff, nxt_hist;
    function automatic logic [15:0] upd(input logic [15:0] o, input logic [31:0] d, input logic [3:0] s);
        return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction
    always_comb begin
        wr = psel && penable && pwrite;
        quiet = !wr && hist_ff == 3'h0;
        nxt_hist = {hist_ff[1:0], wr};
        nxt_sub = (wr && paddr == ADDR_SUBMODE && pstrb[0]) ? pwdata[0] : sub_ff;
        nxt_max = (wr && paddr == ADDR_MAX_CUR) ? upd(max_ff, pwdata, pstrb) : max_ff;
        nxt_rated = (wr && paddr == ADDR_RATED) ? upd(rated_ff, pwdata, pstrb) : rated_ff;
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hist_ff <= 3'h0;
            sub_ff <= 1'b0;
            max_ff <= 16'h0;
            rated_ff <= 16'h0;
        end else begin
            hist_ff <= nxt_hist;
            sub_ff <= nxt_sub;
            max_ff <= nxt_max;
            rated_ff <= nxt_rated;
        end
    end
    // **********
    // Assertions
    // **********
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence rated_sel;
        limiter_active && current_limit_ma == rated_ff && measured_current_ma >= rated_ff && quiet;
    endsequence
    sequence status_rd;
        psel && penable && !pwrite && paddr == ADDR_STATUS;
    endsequence
    sequence limit_rd;
        psel && penable && !pwrite && paddr == ADDR_LIMIT;
    endsequence
    closed_loop_a: assert property (!sub_ff && quiet |-> !limiter_active)
        else $error("limiter active outside closed loop");
    idle_limit_a: assert property (!limiter_active && quiet |-> current_limit_ma == max_ff)
        else $error("inactive limit differs from motor maximum");
    limit_cap_a: assert property (quiet |-> current_limit_ma <= max_ff)
        else $error("limit above motor maximum");
    floor_rated_a: assert property (limiter_active && quiet |-> current_limit_ma >= rated_ff)
        else $error("active limit below rated current");
    active_valid_a: assert property (limiter_active && quiet |-> max_ff > rated_ff && rated_ff != 16'h0)
        else $error("limiter active with invalid settings");
    rated_hold_a: assert property (rated_sel |=> current_limit_ma == rated_ff)
        else $error("left rated limit while overloaded");
    status_read_a: assert property (status_rd |-> prdata == {31'h0, $past(limiter_active)})
        else $error("status read differs from state");
    limit_read_a: assert property (limit_rd |-> prdata == {16'h0, $past(current_limit_ma)})
        else $error("limit read differs from applied limit");
endmodule
bind ovl_limiter_top ovl_limiter_monitor mon_u(.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .measured_current_ma(measured_current_ma), .current_limit_ma(current_limit_ma),
    .limiter_active(limiter_active));
`default_nettype wire

// *** test/ovl_drive_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ovl_drive_model
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Demand and limit
    input wire logic slow,
    input wire logic [15:0] demand_ma,
    input wire logic [15:0] current_limit_ma,
    // Measured current
    output logic [15:0] measured_current_ma
);
    // Slow mode follows only every other cycle, like a lagging loop
    logic ph_ff, nxt_ph;
    logic [15:0] nxt_meas;
    always_comb begin
        nxt_ph = ~ph_ff;
        nxt_meas = measured_current_ma;
        if (!slow || ph_ff) begin
            nxt_meas = (demand_ma < current_limit_ma) ? demand_ma : current_limit_ma;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ph_ff <= 1'b0;
            measured_current_ma <= 16'h0;
        end else begin
            ph_ff <= nxt_ph;
            measured_current_ma <= nxt_meas;
        end
    end
endmodule
`default_nettype wire

// *** test/ovl_limiter_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module ovl_limiter_bench
    import ovl_pkg::*;
;
    localparam int TL = 10;
    logic clock, rst_b, psel, penable, pwrite, pready, pslverr, limiter_active, slow, er, v;
    logic [7:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, rd, thr;
    logic [15:0] meas, lim, demand, mx, rt, ps, du, pk;
    logic [15:0] bad [4][5];
    int error_cnt, comparisons, seed, n, i, c1, c2;
    ovl_limiter_top #(.TICK_LEN(TL)) dut_u(.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .measured_current_ma(meas), .current_limit_ma(lim), .limiter_active(limiter_active));
    ovl_drive_model drv_u(.clock(clock), .rst_b(rst_b), .slow(slow), .demand_ma(demand),
        .current_limit_ma(lim), .measured_current_ma(meas));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #300000;
        error_cnt++;
        complete_run();
    end
    // **********
    // Helpers
    // **********
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("error_cnt=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        // Request held until the edge that sees pready high
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) error_cnt++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task cfg(input logic s);
        apb(1'b1, ADDR_SUBMODE, 32'h0);
        apb(1'b1, ADDR_MAX_CUR, {16'h0, mx});
        apb(1'b1, ADDR_RATED, {16'h0, rt});
        apb(1'b1, ADDR_PEAK_SET, {16'h0, ps});
        apb(1'b1, ADDR_PEAK_DUR, {16'h0, du});
        apb(1'b1, ADDR_SUBMODE, {31'h0, s});
        repeat (4) @(posedge clock);
    endtask
    task expect_state(input logic s);
        logic [31:0] t;
        logic [63:0] b;
        t = {16'h0, rt} * {16'h0, ps} / 32'h3e8;
        pk = (t > {16'h0, mx}) ? mx : t[15:0];
        v = s && mx != 16'h0 && rt != 16'h0 && du != 16'h0 && pk > rt;
        b = v ? ({48'h0, pk} * pk - {48'h0, rt} * rt) * du / 64'hf4240 : 64'h0;
        thr = b[31:0];
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd, {31'h0, v});
        apb(1'b0, ADDR_LIMIT, 32'h0);
        check(rd, {16'h0, v ? pk : mx});
        apb(1'b0, ADDR_THRESH, 32'h0);
        check(rd, thr);
    endtask
    task wait_lim(input logic [15:0] d, input logic [15:0] goal, output int cyc);
        demand <= d;
        cyc = 0;
        do begin
            @(negedge clock);
            cyc++;
        end while (lim !== goal && cyc < 3000);
        @(posedge clock);
    endtask
    // **********
    // Sequence
    // **********
    initial begin
        {psel, penable, pwrite, slow, rst_b} = 5'h0;
        {paddr, pwdata, demand} = 56'h0;
        pstrb = 4'hf;
        seed = 96213;
        bad = '{'{16'h0, 16'hbb8, 16'h3e8, 16'h7d0, 16'ha}, '{16'h1, 16'hbb8, 16'h3e8, 16'h384, 16'ha},
                '{16'h1, 16'hbb8, 16'h3e8, 16'h7d0, 16'h0}, '{16'h1, 16'h320, 16'h3e8, 16'h7d0, 16'ha}};
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        for (i = 0; i <= 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check(rd, 32'h0);
        end
        apb(1'b1, ADDR_LOAD, 32'hffff);
        apb(1'b0, ADDR_LOAD, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        check({31'h0, er}, 32'h1);
        for (i = 0; i < 4; i++) begin
            {mx, rt, ps, du} = {bad[i][1], bad[i][2], bad[i][3], bad[i][4]};
            cfg(bad[i][0][0]);
            expect_state(bad[i][0][0]);
        end
        for (i = 0; i < 4; i++) begin
            slow <= i[0];
            rt = 16'h1f4 + ($random(seed) & 16'h3ff);
            ps = 16'h44c + ($random(seed) & 16'h3ff);
            mx = rt + 16'h40 + ($random(seed) & 16'hfff);
            du = 16'h1 + ($random(seed) & 16'hf);
            cfg(1'b1);
            expect_state(1'b1);
            wait_lim(16'hffff, rt, c1);
            check({31'h0, c1 >= (du - 1) * TL && c1 <= (du + 1) * TL}, 32'h1);
            apb(1'b0, ADDR_LOAD, 32'h0);
            check(rd, thr);
            apb(1'b0, ADDR_LIMIT, 32'h0);
            check(rd, {16'h0, rt});
            wait_lim(16'h0, pk, c2);
            check({16'h0, lim}, {16'h0, pk});
            repeat ((4 * du + 2) * TL) @(posedge clock);
            apb(1'b0, ADDR_LOAD, 32'h0);
            check(rd, 32'h0);
            wait_lim((pk + rt) / 2, rt, c2);
            check({31'h0, c2 > c1 && c2 < 3000}, 32'h1);
            demand <= 16'h0;
        end
        complete_run();
    end
endmodule
`default_nettype wire
